/* File: core/rtcha_device.sv */
// rtc end of the three-wire link: serial slave, timekeeping, alarms, periodic irq
// assumes link pins are asynchronous to i_mclk and the host keeps its own rules
// Contract
// RULE_01: halt sensing armed only while ce low
// RULE_02: host keeps ce low at power-up
// RULE_03: host drops ce when shutting down
// RULE_04: ce fall aborts read, no state change
// RULE_05: write commits in nibbles, upper nibble kept; code commits the whole byte only at the eighth data bit, abort writes nothing
// RULE_06: next cycle after abort works normally
// RULE_07: host waits init time before access
// RULE_08: halt flag 1 from cold, 0 from battery
// RULE_09: host initialises regardless of halt flag
// RULE_10: seconds write clears sub-second divider
// RULE_11: irq-synced read skips wait within 1s
// RULE_12: host writes 0 to periodic flag
// RULE_13: host clears alarm enables before setup
// RULE_14: host enables alarms after all writes
// RULE_15: cancel alarms by writing fixed patterns
// RULE_16: first read after time write reads all
// RULE_17: level periodic irq per sec/min/hour/month
// RULE_18: writing 0 releases alarm, 1 ignored
`timescale 1ns/1ps
`include "rtcha_consts.svh"
module rtcha_device import rtcha_pkg::*; #(
  parameter int unsigned P_TICKS_PER_SEC = `RTCHA_CLK_HZ
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // link
  rtcha_if.device link,
  // crystal status and power source strap
  input wire logic i_osc_stop,
  input wire logic i_from_battery,
  // status
  output logic o_osc_halt_flag
);
  localparam int unsigned P_TOP = P_TICKS_PER_SEC - 1;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic ce_s1, ce_s2, sclk_s1, sclk_s2, sclk_s3, sio_s1, sio_s2;
  logic stop_s1, stop_s2, batt_s1, batt_s2;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {ce_s1, ce_s2, sclk_s1, sclk_s2, sclk_s3, sio_s1, sio_s2} <= 7'h00;
      {stop_s1, stop_s2, batt_s1, batt_s2} <= 4'h0;
    end else begin
      ce_s1 <= link.ce;
      ce_s2 <= ce_s1;
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      sio_s1 <= link.sio;
      sio_s2 <= sio_s1;
      stop_s1 <= i_osc_stop;
      stop_s2 <= stop_s1;
      batt_s1 <= i_from_battery;
      batt_s2 <= batt_s1;
    end
  end
  wire sclk_rise = sclk_s2 & ~sclk_s3;

  // ************************************************************
  // state
  // ************************************************************
  rtcha_dst_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] addr_reg, addr_next;
  logic [3:0] nib_reg, nib_next;
  logic [7:0] out_reg, out_next;
  logic sio_oe_n_reg, sio_oe_n_next;
  logic [31:0] div_reg, div_next;
  logic [7:0] tk_reg [0:6];
  logic [7:0] tk_next [0:6];
  logic [7:0] aw_reg [0:2];
  logic [7:0] aw_next [0:2];
  logic [7:0] ad_reg [0:1];
  logic [7:0] ad_next [0:1];
  logic [7:0] c1_reg, c1_next;
  logic ohf_reg, ohf_next, wafg_reg, wafg_next, dafg_reg, dafg_next;
  logic periodic_irq_flag_reg, periodic_irq_flag_next, irq_oe_n_reg, irq_oe_n_next;
  logic [1:0] boot_reg, boot_next;

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    wrap_inc = (v >= hi) ? lo : v + 8'h01;
  endfunction

  function automatic logic [7:0] rd_mux(input logic [3:0] a);
    rd_mux = 8'h00;
    if (a <= `RTCHA_A_YEAR) begin
      rd_mux = tk_reg[a[2:0]];
    end else if (a == `RTCHA_A_AW_MIN) begin
      rd_mux = aw_reg[0];
    end else if (a == `RTCHA_A_AW_HOUR) begin
      rd_mux = aw_reg[1];
    end else if (a == `RTCHA_A_AW_WDAY) begin
      rd_mux = aw_reg[2];
    end else if (a == `RTCHA_A_AD_MIN) begin
      rd_mux = ad_reg[0];
    end else if (a == `RTCHA_A_AD_HOUR) begin
      rd_mux = ad_reg[1];
    end else if (a == `RTCHA_A_CTRL1) begin
      rd_mux = c1_reg;
    end else if (a == `RTCHA_A_CTRL2) begin
      rd_mux = {3'h0, ohf_reg, 1'b0, periodic_irq_flag_reg, wafg_reg, dafg_reg};
    end
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  logic tick, ev_min, ev_hour, ev_day, ev_month, per_ev, aw_hit, ad_hit, pulse_low;
  logic wr_en;
  logic [7:0] wr_data;
  logic [2:0] ct;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    addr_next = addr_reg;
    nib_next = nib_reg;
    out_next = out_reg;
    sio_oe_n_next = sio_oe_n_reg;
    c1_next = c1_reg;
    ohf_next = ohf_reg;
    wafg_next = wafg_reg;
    dafg_next = dafg_reg;
    periodic_irq_flag_next = periodic_irq_flag_reg;
    boot_next = boot_reg;
    for (int i = 0; i < 7; i++) begin
      tk_next[i] = tk_reg[i];
    end
    for (int i = 0; i < 3; i++) begin
      aw_next[i] = aw_reg[i];
    end
    ad_next[0] = ad_reg[0];
    ad_next[1] = ad_reg[1];
    wr_en = 1'b0;
    wr_data = {nib_reg, sh_reg[2:0], sio_s2};
    ct = c1_reg[2:0];

    // timekeeping chain, binary counts, months of 31 days
    tick = (div_reg == P_TOP);
    div_next = tick ? 32'h0 : div_reg + 32'h1;
    ev_min = tick & (tk_reg[0] == 8'd59);
    ev_hour = ev_min & (tk_reg[1] == 8'd59);
    ev_day = ev_hour & (tk_reg[2] == 8'd23);
    ev_month = ev_day & (tk_reg[4] == 8'd31);
    if (tick) tk_next[0] = wrap_inc(tk_reg[0], 8'd0, 8'd59);
    if (ev_min) tk_next[1] = wrap_inc(tk_reg[1], 8'd0, 8'd59);
    if (ev_hour) tk_next[2] = wrap_inc(tk_reg[2], 8'd0, 8'd23);
    if (ev_day) tk_next[3] = wrap_inc(tk_reg[3], 8'd0, 8'd6);
    if (ev_day) tk_next[4] = wrap_inc(tk_reg[4], 8'd1, 8'd31);
    if (ev_month) tk_next[5] = wrap_inc(tk_reg[5], 8'd1, 8'd12);
    if (ev_month && tk_reg[5] == 8'd12) tk_next[6] = wrap_inc(tk_reg[6], 8'd0, 8'd99);

    // periodic events at the period chosen in ctrl1, alarm events taken at the new minute
    per_ev = ((ct == `RTCHA_CT_SEC) & tick) | ((ct == `RTCHA_CT_MIN) & ev_min) // RULE_17
           | ((ct == `RTCHA_CT_HOUR) & ev_hour) | ((ct == `RTCHA_CT_MONTH) & ev_month);
    aw_hit = ev_min & c1_reg[`RTCHA_C1_WEEKDAY_ALARM_ENABLE] & (tk_next[1] == aw_reg[0])
           & (tk_next[2] == aw_reg[1]) & aw_reg[2][tk_next[3][2:0]];
    ad_hit = ev_min & c1_reg[`RTCHA_C1_DAILY_ALARM_ENABLE] & (tk_next[1] == ad_reg[0])
           & (tk_next[2] == ad_reg[1]);

    // serial slave; ce low drops any cycle, committed state untouched
    if (!ce_s2) begin
      st_next = RTCHA_D_IDLE; // RULE_04
      sio_oe_n_next = 1'b1;
    end else begin
      case (st_reg)
        RTCHA_D_IDLE: begin
          st_next = RTCHA_D_CMD; // RULE_06
          cnt_next = 3'h0;
        end
        RTCHA_D_CMD: begin
          if (sclk_rise) begin
            sh_next = {sh_reg[6:0], sio_s2};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
              addr_next = sh_reg[6:3];
              if ({sh_reg[2:0], sio_s2} == `RTCHA_MODE_RD) begin
                st_next = RTCHA_D_RD;
                out_next = rd_mux(sh_reg[6:3]);
                sio_oe_n_next = 1'b0;
              end else if ({sh_reg[2:0], sio_s2} == `RTCHA_MODE_WR) begin
                st_next = RTCHA_D_WR;
              end else begin
                st_next = RTCHA_D_IDLE;
              end
            end
          end
        end
        RTCHA_D_WR: begin
          if (sclk_rise) begin
            sh_next = {sh_reg[6:0], sio_s2};
            cnt_next = cnt_reg + 3'h1;
            if (cnt_reg == 3'h3) nib_next = {sh_reg[2:0], sio_s2}; // RULE_05
            if (cnt_reg == 3'h7) begin
              wr_en = 1'b1; // RULE_05
              st_next = RTCHA_D_IDLE;
            end
          end
        end
        RTCHA_D_RD: begin
          // host samples on the rising edge, so shift after it
          if (sclk_rise) begin
            out_next = {out_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 3'h1;
          end
        end
        default: st_next = RTCHA_D_IDLE;
      endcase
    end

    // register writes override the counting above
    if (wr_en) begin
      if (addr_reg <= `RTCHA_A_YEAR) tk_next[addr_reg[2:0]] = wr_data;
      if (addr_reg == `RTCHA_A_SEC) div_next = 32'h0; // RULE_10
      if (addr_reg == `RTCHA_A_AW_MIN) aw_next[0] = wr_data;
      if (addr_reg == `RTCHA_A_AW_HOUR) aw_next[1] = wr_data;
      if (addr_reg == `RTCHA_A_AW_WDAY) aw_next[2] = wr_data;
      if (addr_reg == `RTCHA_A_AD_MIN) ad_next[0] = wr_data;
      if (addr_reg == `RTCHA_A_AD_HOUR) ad_next[1] = wr_data;
      if (addr_reg == `RTCHA_A_CTRL1) c1_next = wr_data;
      if (addr_reg == `RTCHA_A_CTRL2) begin
        // zero clears, one leaves the flag alone
        ohf_next = ohf_reg & wr_data[`RTCHA_C2_OHF];
        periodic_irq_flag_next = periodic_irq_flag_reg & wr_data[`RTCHA_C2_PERIODIC_IRQ_FLAG];
        wafg_next = wafg_reg & wr_data[`RTCHA_C2_WAFG]; // RULE_18
        dafg_next = dafg_reg & wr_data[`RTCHA_C2_DAFG]; // RULE_18
      end
    end

    // sets after clears so a coincident event is kept
    periodic_irq_flag_next = periodic_irq_flag_next | per_ev; // RULE_17
    wafg_next = wafg_next | aw_hit;
    dafg_next = dafg_next | ad_hit;
    // strap settles through the synchroniser before it is caught
    if (boot_reg != 2'h3) begin
      boot_next = boot_reg + 2'h1;
      if (boot_reg == 2'h2) ohf_next = ~batt_s2; // RULE_08
    end else if (stop_s2 && !ce_s2) begin
      ohf_next = 1'b1; // RULE_01
    end

    // open-drain interrupt, low while any source is active
    pulse_low = (ct == `RTCHA_CT_1HZ) ? (div_reg < P_TICKS_PER_SEC / 2)
              : (div_reg < P_TICKS_PER_SEC / 4)
                | ((div_reg >= P_TICKS_PER_SEC / 2) & (div_reg < 3 * (P_TICKS_PER_SEC / 4)));
    irq_oe_n_next = ~(wafg_next | dafg_next | (ct[2] & periodic_irq_flag_next) // RULE_18
                    | (ct == `RTCHA_CT_FIX_LOW) | ((ct[2:1] == 2'b01) & pulse_low));
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= RTCHA_D_IDLE;
      cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      addr_reg <= 4'h0;
      nib_reg <= 4'h0;
      out_reg <= 8'h00;
      sio_oe_n_reg <= 1'b1;
      div_reg <= 32'h0;
      for (int i = 0; i < 7; i++) begin
        tk_reg[i] <= 8'h00;
      end
      for (int i = 0; i < 3; i++) begin
        aw_reg[i] <= 8'h00;
      end
      ad_reg[0] <= 8'h00;
      ad_reg[1] <= 8'h00;
      c1_reg <= `RTCHA_CTRL1_RST;
      ohf_reg <= 1'b1;
      wafg_reg <= 1'b0;
      dafg_reg <= 1'b0;
      periodic_irq_flag_reg <= 1'b0;
      irq_oe_n_reg <= 1'b1;
      boot_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      nib_reg <= nib_next;
      out_reg <= out_next;
      sio_oe_n_reg <= sio_oe_n_next;
      div_reg <= div_next;
      tk_reg <= tk_next;
      aw_reg <= aw_next;
      ad_reg <= ad_next;
      c1_reg <= c1_next;
      ohf_reg <= ohf_next;
      wafg_reg <= wafg_next;
      dafg_reg <= dafg_next;
      periodic_irq_flag_reg <= periodic_irq_flag_next;
      irq_oe_n_reg <= irq_oe_n_next;
      boot_reg <= boot_next;
    end
  end

  assign link.dev_sio_o = out_reg[7];
  assign link.dev_sio_oe_n = sio_oe_n_reg;
  assign link.irq_n_oe_n = irq_oe_n_reg;
  assign o_osc_halt_flag = ohf_reg;
endmodule // rtcha_device

/* File: core/rtcha_host.sv */
// host end of the three-wire link, commanded over an avalon-mm slave
// assumes software runs the power-up, time, alarm and irq sequences
`timescale 1ns/1ps
`include "rtcha_consts.svh"
module rtcha_host import rtcha_pkg::*; #(
  parameter int unsigned P_INIT_CYCLES = `RTCHA_INIT_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // system power state
  input wire logic i_shutdown,
  // link
  rtcha_if.host link
);
  localparam logic [7:0] P_HALF = 8'(`RTCHA_SCLK_HALF);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic sio_s1, sio_s2, irq_s1, irq_s2;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {sio_s1, sio_s2, irq_s1, irq_s2} <= 4'hF;
    end else begin
      sio_s1 <= link.sio;
      sio_s2 <= sio_s1;
      irq_s1 <= link.irq_n_pin;
      irq_s2 <= irq_s1;
    end
  end

  // ************************************************************
  // state
  // ************************************************************
  rtcha_hst_t st_reg, st_next;
  logic [31:0] init_reg, init_next;
  logic [7:0] ph_reg, ph_next;
  logic [4:0] bit_reg, bit_next;
  logic [15:0] tx_reg, tx_next;
  logic [7:0] rx_reg, rx_next;
  logic rd_op_reg, rd_op_next, ce_reg, ce_next, sclk_reg, sclk_next;
  logic sio_reg, sio_next, oe_n_reg, oe_n_next, wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic busy, ready, cmd_wr, accept;

  always_comb begin
    st_next = st_reg;
    init_next = init_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rd_op_next = rd_op_reg;
    ce_next = ce_reg;
    sclk_next = sclk_reg;
    sio_next = sio_reg;
    oe_n_next = oe_n_reg;
    rdata_next = rdata_reg;
    busy = (st_reg != RTCHA_H_IDLE);
    // commands wait out oscillator start after power-up
    ready = (init_reg == P_INIT_CYCLES); // RULE_07
    if (!ready) init_next = init_reg + 32'h1;
    cmd_wr = i_avs_write & (i_avs_address == `RTCHA_HR_CMD);
    // a command write stalls while busy; software sequences go through here
    accept = (i_avs_read | i_avs_write) & wait_reg
           & ~(cmd_wr & (busy | ~ready | i_shutdown)); // RULE_13 RULE_14 RULE_15
    wait_next = ~accept;
    if (accept && i_avs_read) begin
      if (i_avs_address == `RTCHA_HR_STATUS) begin
        rdata_next = {16'h0, rx_reg, 5'h0, ~irq_s2, ready, busy}; // RULE_12 RULE_16
      end else begin
        rdata_next = 32'h0;
      end
    end
    case (st_reg)
      RTCHA_H_IDLE: begin
        if (accept && cmd_wr) begin
          rd_op_next = i_avs_writedata[`RTCHA_CMD_RD_BIT];
          tx_next = {i_avs_writedata[11:8],
                     i_avs_writedata[`RTCHA_CMD_RD_BIT] ? `RTCHA_MODE_RD : `RTCHA_MODE_WR,
                     i_avs_writedata[7:0]};
          ce_next = 1'b1;
          ph_next = 8'h0;
          st_next = RTCHA_H_SETUP;
        end
      end
      RTCHA_H_SETUP: begin
        ph_next = ph_reg + 8'h1;
        if (ph_reg == P_HALF) begin
          ph_next = 8'h0;
          bit_next = 5'h0;
          sio_next = tx_reg[15];
          oe_n_next = 1'b0;
          st_next = RTCHA_H_SHIFT;
        end
      end
      RTCHA_H_SHIFT: begin
        ph_next = ph_reg + 8'h1;
        if (ph_reg == P_HALF) begin
          ph_next = 8'h0;
          sclk_next = ~sclk_reg;
          if (!sclk_reg) begin
            if (rd_op_reg && bit_reg >= 5'd8) rx_next = {rx_reg[6:0], sio_s2};
            bit_next = bit_reg + 5'h1;
            tx_next = {tx_reg[14:0], 1'b0};
          end else if (bit_reg == 5'd16) begin
            oe_n_next = 1'b1;
            st_next = RTCHA_H_END;
          end else begin
            sio_next = tx_reg[15];
            // data phase of a read belongs to the device
            oe_n_next = rd_op_reg && bit_reg >= 5'd8; // RULE_11
          end
        end
      end
      RTCHA_H_END: begin
        ph_next = ph_reg + 8'h1;
        if (ph_reg == P_HALF) begin
          ce_next = 1'b0;
          st_next = RTCHA_H_IDLE;
        end
      end
      default: st_next = RTCHA_H_IDLE;
    endcase
    if (i_shutdown) begin
      ce_next = 1'b0; // RULE_03
      sclk_next = 1'b0;
      oe_n_next = 1'b1;
      st_next = RTCHA_H_IDLE;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= RTCHA_H_IDLE;
      init_reg <= 32'h0; // RULE_09
      ph_reg <= 8'h0;
      bit_reg <= 5'h0;
      tx_reg <= 16'h0;
      rx_reg <= 8'h0;
      rd_op_reg <= 1'b0;
      ce_reg <= 1'b0; // RULE_02
      sclk_reg <= 1'b0;
      sio_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      init_reg <= init_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rd_op_reg <= rd_op_next;
      ce_reg <= ce_next;
      sclk_reg <= sclk_next;
      sio_reg <= sio_next;
      oe_n_reg <= oe_n_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.ce = ce_reg;
  assign link.sclk = sclk_reg;
  assign link.host_sio_o = sio_reg;
  assign link.host_sio_oe_n = oe_n_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
endmodule // rtcha_host

/* File: pkg/rtcha_consts.svh */
// constants for the rtc host-access link: register map, fields, timing
// assumes inclusion by bare name from core/ files and the bench
`ifndef RTCHA_CONSTS_SVH
`define RTCHA_CONSTS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define RTCHA_CLK_HZ 200000000
`define RTCHA_CLK_NS 5
`define RTCHA_INIT_WAIT_MS 2000
`define RTCHA_INIT_CYCLES (`RTCHA_INIT_WAIT_MS * (`RTCHA_CLK_HZ / 1000))
`define RTCHA_SCLK_HALF_NS 125
`define RTCHA_SCLK_HALF ((`RTCHA_SCLK_HALF_NS + `RTCHA_CLK_NS - 1) / `RTCHA_CLK_NS)

// ************************************************************
// serial command nibble and device register addresses
// ************************************************************
`define RTCHA_MODE_WR 4'h0
`define RTCHA_MODE_RD 4'hC
`define RTCHA_A_SEC 4'h0
`define RTCHA_A_MIN 4'h1
`define RTCHA_A_HOUR 4'h2
`define RTCHA_A_WDAY 4'h3
`define RTCHA_A_DAY 4'h4
`define RTCHA_A_MONTH 4'h5
`define RTCHA_A_YEAR 4'h6
`define RTCHA_A_AW_MIN 4'h8
`define RTCHA_A_AW_HOUR 4'h9
`define RTCHA_A_AW_WDAY 4'hA
`define RTCHA_A_AD_MIN 4'hB
`define RTCHA_A_AD_HOUR 4'hC
`define RTCHA_A_CTRL1 4'hE
`define RTCHA_A_CTRL2 4'hF

// ************************************************************
// control fields and reset values
// ************************************************************
`define RTCHA_C1_WEEKDAY_ALARM_ENABLE 7
`define RTCHA_C1_DAILY_ALARM_ENABLE 6
`define RTCHA_C2_OHF 4
`define RTCHA_C2_PERIODIC_IRQ_FLAG 2
`define RTCHA_C2_WAFG 1
`define RTCHA_C2_DAFG 0
`define RTCHA_CTRL1_RST 8'h00
`define RTCHA_CT_FIX_LOW 3'h1
`define RTCHA_CT_2HZ 3'h2
`define RTCHA_CT_1HZ 3'h3
`define RTCHA_CT_SEC 3'h4
`define RTCHA_CT_MIN 3'h5
`define RTCHA_CT_HOUR 3'h6
`define RTCHA_CT_MONTH 3'h7

// ************************************************************
// host avalon register map
// ************************************************************
`define RTCHA_HR_CMD 4'h0
`define RTCHA_HR_STATUS 4'h4
`define RTCHA_CMD_RD_BIT 15

`endif

/* File: pkg/rtcha_if.sv */
// three-wire link plus open-drain interrupt line between host and rtc
// assumes the bench joins both ends through one instance
`timescale 1ns/1ps
interface rtcha_if;
  logic ce;
  logic sclk;
  logic host_sio_o;
  logic host_sio_oe_n;
  logic dev_sio_o;
  logic dev_sio_oe_n;
  logic sio;
  logic irq_n_oe_n;
  logic irq_n_pin;

  // resolved wire levels; released lines pull high
  assign sio = !host_sio_oe_n ? host_sio_o : (!dev_sio_oe_n ? dev_sio_o : 1'b1);
  assign irq_n_pin = irq_n_oe_n ? 1'b1 : 1'b0;

  modport host (output ce, output sclk, output host_sio_o, output host_sio_oe_n,
                input sio, input irq_n_pin);
  modport device (input ce, input sclk, input sio, output dev_sio_o,
                  output dev_sio_oe_n, output irq_n_oe_n);
endinterface

/* File: pkg/rtcha_pkg.sv */
// types shared by both ends of the rtc serial link
// assumes nothing beyond a sv compiler
package rtcha_pkg;
  typedef enum logic [3:0] {
    RTCHA_D_IDLE = 4'b0001,
    RTCHA_D_CMD = 4'b0010,
    RTCHA_D_WR = 4'b0100,
    RTCHA_D_RD = 4'b1000
  } rtcha_dst_t;
  typedef enum logic [3:0] {
    RTCHA_H_IDLE = 4'b0001,
    RTCHA_H_SETUP = 4'b0010,
    RTCHA_H_SHIFT = 4'b0100,
    RTCHA_H_END = 4'b1000
  } rtcha_hst_t;
endpackage

/* File: sim/rtcha_checker.sv */
// link checker for the host-rtc three-wire interface
// assumes tb wires it to the interface signals beside the link instance
`timescale 1ns/1ps
module rtcha_checker (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // link
  input wire logic ce,
  input wire logic sclk,
  input wire logic dev_sio_oe_n,
  input wire logic irq_n_oe_n
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // ********
  // properties
  // ********
  property p_rst_idle; $rose(i_rst_b) |-> !ce; endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("ce high after reset");
  property p_sclk_framed; $rose(sclk) |-> ce; endproperty
  a_sclk_framed: assert property (p_sclk_framed)
    else $error("sclk rose outside frame");
  property p_dev_release; $fell(ce) |-> ##[0:8] dev_sio_oe_n; endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("device still drives after ce fall");
  property p_dev_drive; $fell(dev_sio_oe_n) |-> ce; endproperty
  a_dev_drive: assert property (p_dev_drive)
    else $error("device drives without ce");
  property p_dev_quiet; (!ce) [*8] |-> dev_sio_oe_n; endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives while idle");
  property p_irq_rel; $rose(irq_n_oe_n) |-> ce; endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("irq released without a write");
  property p_frame_min; $rose(ce) |=> ce [*8]; endproperty
  a_frame_min: assert property (p_frame_min)
    else $error("frame too short");
  property p_setup; $rose(ce) |-> !sclk [*8]; endproperty
  a_setup: assert property (p_setup)
    else $error("sclk moved in ce setup");
  c_frame: cover property ($rose(ce));
  c_read: cover property ($fell(dev_sio_oe_n));
  c_irq: cover property ($fell(irq_n_oe_n));
endmodule // rtcha_checker

/* File: sim/tb.sv */
// self-checking bench: host and rtc joined by one link instance
// assumes both design ends and the link interface are compiled first
`timescale 1ns/1ps
`include "rtcha_consts.svh"
module tb;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic shut = 1'b0;
  logic osc_stop = 1'b0;
  logic batt = 1'b0;
  logic halt;
  logic [31:0] q;
  int err_total = 0;
  int checked = 0;
  always #2.5 mclk = ~mclk;
  rtcha_if lnk();
  rtcha_host #(.P_INIT_CYCLES(100)) i_rtcha_host (.i_mclk(mclk), .i_rst_b(rst_b),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_shutdown(shut), .link(lnk));
  // one second shortened so a tick fits a few frames
  rtcha_device #(.P_TICKS_PER_SEC(4000)) i_rtcha_device (.i_mclk(mclk), .i_rst_b(rst_b),
    .link(lnk), .i_osc_stop(osc_stop), .i_from_battery(batt), .o_osc_halt_flag(halt));
  rtcha_checker i_rtcha_checker (.i_mclk(mclk), .i_rst_b(rst_b), .ce(lnk.ce),
    .sclk(lnk.sclk), .dev_sio_oe_n(lnk.dev_sio_oe_n), .irq_n_oe_n(lnk.irq_n_oe_n));
  // ********
  // tasks
  // ********
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // called just after a rising edge; returns one idle cycle after release
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 20000);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20000) begin
      err_total++;
      stop_test();
    end
    @(posedge mclk);
  endtask
  task automatic poll(input int b, input logic v);
    int n;
    for (n = 0; n < 3000; n++) begin
      av(1'b0, `RTCHA_HR_STATUS, 32'h0);
      if (q[b] === v) break;
    end
    if (n >= 3000) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic dw(input logic [3:0] a, input logic [7:0] d);
    av(1'b1, `RTCHA_HR_CMD, {20'h0, a, d});
    poll(0, 1'b0);
  endtask
  task automatic dr(input logic [3:0] a);
    av(1'b1, `RTCHA_HR_CMD, {16'h0, 4'h8, a, 8'h0});
    poll(0, 1'b0);
    q = {24'h0, q[15:8]};
  endtask
  task automatic cut(input int c);
    repeat (c) @(posedge mclk);
    shut <= 1'b1;
    @(posedge mclk);
    shut <= 1'b0;
    poll(0, 1'b0);
  endtask
  // ********
  // sequence
  // ********
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    chk("halt_cold", {31'h0, halt}, 32'h1);
    poll(1, 1'b1);
    dw(`RTCHA_A_CTRL2, 8'h00);
    chk("halt_cleared", {31'h0, halt}, 32'h0);
    fork
      begin
        wait (lnk.ce === 1'b1);
        repeat (40) @(posedge mclk);
        osc_stop <= 1'b1;
        repeat (40) @(posedge mclk);
        osc_stop <= 1'b0;
      end
    join_none
    dw(`RTCHA_A_SEC, 8'h05);
    chk("halt_ce_high", {31'h0, halt}, 32'h0);
    dr(`RTCHA_A_SEC);
    chk("sec", q, 32'h05);
    osc_stop <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("halt_ce_low", {31'h0, halt}, 32'h1);
    osc_stop <= 1'b0;
    $display("test halt_sec done");
    dw(`RTCHA_A_MIN, 8'h2A);
    // cut between upper nibble and commit
    av(1'b1, `RTCHA_HR_CMD, {20'h0, `RTCHA_A_MIN, 8'hD5});
    cut(700);
    dr(`RTCHA_A_MIN);
    chk("min_wr_abort", q, 32'h2A);
    dw(`RTCHA_A_MIN, 8'h15);
    av(1'b1, `RTCHA_HR_CMD, {16'h0, 4'h8, `RTCHA_A_MIN, 8'h0});
    // cut inside the data phase, while the rtc drives sio
    cut(600);
    dr(`RTCHA_A_MIN);
    chk("min_next", q, 32'h15);
    $display("test abort done");
    dw(`RTCHA_A_CTRL1, {5'h0, `RTCHA_CT_SEC});
    poll(2, 1'b1);
    chk("irq_low", {31'h0, lnk.irq_n_pin}, 32'h0);
    dw(`RTCHA_A_CTRL2, 8'hFB);
    chk("irq_released", {31'h0, lnk.irq_n_pin}, 32'h1);
    dr(`RTCHA_A_CTRL2);
    chk("ctrl2", q & 32'h14, 32'h10);
    $display("test periodic done");
    dw(`RTCHA_A_CTRL1, 8'h00);
    dw(`RTCHA_A_HOUR, 8'h00);
    dw(`RTCHA_A_MIN, 8'h00);
    dw(`RTCHA_A_AD_MIN, 8'h01);
    dw(`RTCHA_A_AD_HOUR, 8'h00);
    // last second of the minute, so the alarm matches soon
    dw(`RTCHA_A_SEC, 8'h3B);
    dw(`RTCHA_A_CTRL1, 8'h40);
    poll(2, 1'b1);
    dr(`RTCHA_A_CTRL2);
    chk("daily_flag", q & 32'h01, 32'h01);
    dw(`RTCHA_A_AD_MIN, 8'h56);
    dw(`RTCHA_A_AD_HOUR, 8'h56);
    dw(`RTCHA_A_CTRL2, 8'hFE);
    chk("alarm_released", {31'h0, lnk.irq_n_pin}, 32'h1);
    $display("test alarm done");
    rst_b <= 1'b0;
    batt <= 1'b1;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("halt_batt", {31'h0, halt}, 32'h0);
    $display("test battery done");
    stop_test();
  end
endmodule // tb
